/* File: inc/dcp_pkg.sv */
// Constants and types of the peripheral DMA channel engine
package dcp_pkg;
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_CONFIG = 12'h004;
    localparam logic [11:0] OFS_CTL_BASE = 12'h008;
    localparam logic [11:0] OFS_ALT_BASE = 12'h00C;
    localparam logic [11:0] OFS_BURST_ONLY_SET = 12'h018;
    localparam logic [11:0] OFS_BURST_ONLY_CLEAR = 12'h01C;
    localparam logic [11:0] OFS_REQUEST_MASK = 12'h020;
    localparam logic [11:0] OFS_REQUEST_UNMASK = 12'h024;
    localparam logic [11:0] OFS_CHANNEL_ENABLE_SET = 12'h028;
    localparam logic [11:0] OFS_CHANNEL_ENABLE_CLEAR = 12'h02C;
    localparam logic [11:0] OFS_PRIMARY_SELECT_SET = 12'h030;
    localparam logic [11:0] OFS_PRIMARY_SELECT_CLEAR = 12'h034;
    localparam logic [11:0] OFS_CHANNEL_PRIORITY_SET = 12'h038;
    localparam logic [11:0] OFS_CHANNEL_PRIORITY_CLEAR = 12'h03C;

    localparam logic [31:0] CTL_BASE_RESET = 32'h0000_0000;
    localparam logic [31:0] CTL_BASE_MASK = 32'hFFFF_FC00;
    localparam logic [31:0] ALT_STRUCT_OFS = 32'h0000_0200;
    localparam int STRUCT_SHIFT = 4;
    localparam logic [31:0] SRC_END_OFS = 32'h0000_0000;
    localparam logic [31:0] DST_END_OFS = 32'h0000_0004;
    localparam logic [31:0] CTL_WORD_OFS = 32'h0000_0008;

    localparam int DEST_ADDR_STEP_LO = 30;
    localparam int DEST_ITEM_WIDTH_LO = 28;
    localparam int SRC_ADDR_STEP_LO = 26;
    localparam int SRC_ITEM_WIDTH_LO = 24;
    localparam int REARB_LO = 14;
    localparam int COUNT_LO = 4;
    localparam int COUNT_HI = 13;
    localparam int NEXT_BURST_ONLY_BIT = 3;
    localparam int MODE_HI = 2;

    localparam logic [1:0] STEP_BYTE = 2'h0;
    localparam logic [1:0] STEP_FIXED = 2'h3;
    localparam logic [1:0] WIDTH_BYTE = 2'h0;
    localparam logic [3:0] REARB_ALL = 4'hA;
    localparam logic [2:0] MODE_STOP = 3'h0;
    localparam logic [2:0] MODE_BASIC = 3'h1;
    localparam logic [2:0] MODE_PING_PONG = 3'h3;

    typedef struct packed {
        logic req;
        logic we;
        logic item;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dcp_mem_req_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_RD_SRC = 7'b0000010,
        ST_RD_DST = 7'b0000100,
        ST_RD_CTL = 7'b0001000,
        ST_XF_RD = 7'b0010000,
        ST_XF_WR = 7'b0100000,
        ST_WB_CTL = 7'b1000000
    } dcp_state_t;
endpackage

/* File: logic/dcp_dma_channel.sv */
// Multi-channel peripheral DMA engine with basic and ping-pong modes
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module dcp_dma_channel
    import dcp_pkg::*;
#(
    parameter int NUM_CH = 32
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [11:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output dcp_mem_req_t mem_o,
    input wire logic [31:0] mem_rdata_i,
    input wire logic mem_ack_i,
    input wire logic [NUM_CH-1:0] dma_single_i,
    input wire logic [NUM_CH-1:0] dma_burst_i,
    output logic [NUM_CH-1:0] dma_done_o
);
    localparam int CW = $clog2(NUM_CH);

    function automatic logic [CW:0] pick_ch(input logic [NUM_CH-1:0] v);
        logic [CW:0] r;
        r = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, CW'(i)};
            end
        end
        return r;
    endfunction

    // step code 0 moves one byte
    function automatic logic [31:0] item_addr(input logic [31:0] last,
                                              input logic [1:0] step,
                                              input logic [9:0] rem);
        logic [31:0] r;
        r = last;
        if (step != STEP_FIXED) begin
            r = last - (32'(rem) << step);
        end
        return r;
    endfunction

    logic [NUM_CH-1:0] sreq1_q, sreq2_q, breq1_q, breq2_q;
    logic resp_q;
    logic [31:0] rdata_q;
    logic master_en_q;
    logic [31:0] ctl_base_q;
    logic [NUM_CH-1:0] burst_only_q, mask_q, ena_q, alt_q, prio_q;
    dcp_state_t st_q;
    logic [CW-1:0] ch_q;
    logic burst_q, alt_use_q, fin_q;
    logic [31:0] src_end_q, dst_end_q, ctl_q;
    logic [2:0] cur_mode_q;
    logic [9:0] rem_q, grp_q;
    logic [7:0] byte_q;
    logic [NUM_CH-1:0] done_q;

    // Two-flop synchronisers on peripheral request pins
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sreq1_q <= '0;
            sreq2_q <= '0;
            breq1_q <= '0;
            breq2_q <= '0;
        end else begin
            sreq1_q <= dma_single_i;
            sreq2_q <= sreq1_q;
            breq1_q <= dma_burst_i;
            breq2_q <= breq1_q;
        end
    end

    // Avalon slave: one wait cycle, then answer
    logic acc, wr_fire;
    logic [NUM_CH-1:0] wbits;
    assign acc = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = acc & ~resp_q;
    assign wr_fire = avs_write_i & resp_q;
    assign wbits = avs_writedata_i[NUM_CH-1:0];
    assign avs_readdata_o = rdata_q;

    function automatic logic wr_at(input logic [11:0] ofs, input logic f,
                                   input logic [11:0] a);
        return f && (a == ofs);
    endfunction

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            resp_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            resp_q <= acc & ~resp_q;
            if (avs_read_i && !resp_q) begin
                case (avs_address_i)
                    OFS_STATUS: rdata_q <= {30'h0, st_q != ST_IDLE, master_en_q};
                    OFS_CTL_BASE: rdata_q <= ctl_base_q;
                    OFS_ALT_BASE: rdata_q <= ctl_base_q + ALT_STRUCT_OFS;
                    OFS_BURST_ONLY_SET: rdata_q <= 32'(burst_only_q);
                    OFS_REQUEST_MASK: rdata_q <= 32'(mask_q);
                    OFS_CHANNEL_ENABLE_SET: rdata_q <= 32'(ena_q);
                    OFS_PRIMARY_SELECT_SET: rdata_q <= 32'(alt_q);
                    OFS_CHANNEL_PRIORITY_SET: rdata_q <= 32'(prio_q);
                    default: rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            master_en_q <= 1'b0;
            ctl_base_q <= CTL_BASE_RESET;
        end else begin
            if (wr_at(OFS_CONFIG, wr_fire, avs_address_i)) begin
                master_en_q <= avs_writedata_i[0];
            end
            if (wr_at(OFS_CTL_BASE, wr_fire, avs_address_i)) begin
                ctl_base_q <= avs_writedata_i & CTL_BASE_MASK;
            end
        end
    end

    // Engine events that act on channel bits
    logic [NUM_CH-1:0] chbit, hw_clr, hw_tog;
    logic eng_done, bad_mode, ctl_ack;
    assign chbit = NUM_CH'(1) << ch_q;
    assign ctl_ack = (st_q == ST_RD_CTL) && mem_ack_i;
    assign bad_mode = (mem_rdata_i[MODE_HI:0] != MODE_BASIC)
                   && (mem_rdata_i[MODE_HI:0] != MODE_PING_PONG);
    assign eng_done = (st_q == ST_WB_CTL) && mem_ack_i && fin_q;
    // basic done or stopped structure disables
    assign hw_clr = ((eng_done && cur_mode_q == MODE_BASIC) || (ctl_ack && bad_mode))
                  ? chbit : '0;
    assign hw_tog = (eng_done && cur_mode_q == MODE_PING_PONG) ? chbit : '0;

    // bit n of each register acts on channel n
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            burst_only_q <= '0;
            mask_q <= '0;
            prio_q <= '0;
        end else begin
            if (wr_at(OFS_BURST_ONLY_SET, wr_fire, avs_address_i)) begin
                burst_only_q <= burst_only_q | wbits;
            end
            if (wr_at(OFS_BURST_ONLY_CLEAR, wr_fire, avs_address_i)) begin
                burst_only_q <= burst_only_q & ~wbits;
            end
            if (wr_at(OFS_REQUEST_MASK, wr_fire, avs_address_i)) begin
                mask_q <= mask_q | wbits;
            end
            if (wr_at(OFS_REQUEST_UNMASK, wr_fire, avs_address_i)) begin
                mask_q <= mask_q & ~wbits;
            end
            if (wr_at(OFS_CHANNEL_PRIORITY_SET, wr_fire, avs_address_i)) begin
                prio_q <= prio_q | wbits;
            end
            if (wr_at(OFS_CHANNEL_PRIORITY_CLEAR, wr_fire, avs_address_i)) begin
                prio_q <= prio_q & ~wbits;
            end
        end
    end

    // Software set wins over a same-cycle hardware clear
    logic [NUM_CH-1:0] ena_set, ena_clr, alt_set, alt_clr;
    assign ena_set = wr_at(OFS_CHANNEL_ENABLE_SET, wr_fire, avs_address_i) ? wbits : '0;
    assign ena_clr = wr_at(OFS_CHANNEL_ENABLE_CLEAR, wr_fire, avs_address_i) ? wbits : '0;
    assign alt_set = wr_at(OFS_PRIMARY_SELECT_SET, wr_fire, avs_address_i) ? wbits : '0;
    assign alt_clr = wr_at(OFS_PRIMARY_SELECT_CLEAR, wr_fire, avs_address_i) ? wbits : '0;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ena_q <= '0;
            alt_q <= '0;
        end else begin
            ena_q <= (ena_q & ~ena_clr & ~hw_clr) | ena_set;
            alt_q <= ((alt_q ^ hw_tog) & ~alt_clr) | alt_set;
        end
    end

    // Arbitration: high-priority channels first, then lowest number
    logic [NUM_CH-1:0] pend;
    logic [CW:0] pick_hi, pick_all, pick;
    assign pend = master_en_q ? (ena_q & ~mask_q
                & (breq2_q | (sreq2_q & ~burst_only_q))) : '0;
    assign pick_hi = pick_ch(pend & prio_q);
    assign pick_all = pick_ch(pend);
    assign pick = pick_hi[CW] ? pick_hi : pick_all;

    logic [31:0] sbase;
    assign sbase = ctl_base_q + (32'(ch_q) << STRUCT_SHIFT)
                 + (alt_use_q ? ALT_STRUCT_OFS : 32'h0000_0000);

    logic [1:0] src_step, dst_step;
    logic [3:0] rearb;
    assign src_step = ctl_q[SRC_ADDR_STEP_LO+:2];
    assign dst_step = ctl_q[DEST_ADDR_STEP_LO+:2];
    assign rearb = mem_rdata_i[REARB_LO+:4];

    // Memory master request built from engine state
    always_comb begin
        mem_o = '0;
        mem_o.req = (st_q != ST_IDLE);
        case (st_q)
            ST_RD_SRC: mem_o.addr = sbase + SRC_END_OFS;
            ST_RD_DST: mem_o.addr = sbase + DST_END_OFS;
            ST_RD_CTL: mem_o.addr = sbase + CTL_WORD_OFS;
            ST_XF_RD: begin
                mem_o.item = 1'b1;
                // item address from inclusive end pointer
                mem_o.addr = item_addr(src_end_q, src_step, rem_q);
            end
            ST_XF_WR: begin
                mem_o.item = 1'b1;
                mem_o.we = 1'b1;
                mem_o.addr = item_addr(dst_end_q, dst_step, rem_q);
                mem_o.wdata = {24'h00_0000, byte_q};
            end
            ST_WB_CTL: begin
                mem_o.we = 1'b1;
                mem_o.addr = sbase + CTL_WORD_OFS;
                mem_o.wdata = ctl_q;
            end
            default: mem_o.req = 1'b0;
        endcase
    end

    // fetch pointers and control, move, write back
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= ST_IDLE;
            ch_q <= '0;
            burst_q <= 1'b0;
            alt_use_q <= 1'b0;
            fin_q <= 1'b0;
            src_end_q <= 32'h0000_0000;
            dst_end_q <= 32'h0000_0000;
            ctl_q <= 32'h0000_0000;
            cur_mode_q <= MODE_STOP;
            rem_q <= '0;
            grp_q <= '0;
            byte_q <= '0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (pick[CW]) begin
                        ch_q <= pick[CW-1:0];
                        burst_q <= breq2_q[pick[CW-1:0]];
                        alt_use_q <= alt_q[pick[CW-1:0]];
                        st_q <= ST_RD_SRC;
                    end
                end
                ST_RD_SRC: begin
                    if (mem_ack_i) begin
                        src_end_q <= mem_rdata_i;
                        st_q <= ST_RD_DST;
                    end
                end
                ST_RD_DST: begin
                    if (mem_ack_i) begin
                        dst_end_q <= mem_rdata_i;
                        st_q <= ST_RD_CTL;
                    end
                end
                ST_RD_CTL: begin
                    if (mem_ack_i) begin
                        ctl_q <= mem_rdata_i;
                        cur_mode_q <= mem_rdata_i[MODE_HI:0];
                        // count field is items minus one
                        rem_q <= mem_rdata_i[COUNT_HI:COUNT_LO];
                        // burst moves group, single one item
                        if (!burst_q) begin
                            grp_q <= '0;
                        end else if (rearb >= REARB_ALL) begin
                            grp_q <= 10'h3FF;
                        end else begin
                            grp_q <= (10'h001 << rearb) - 10'h001;
                        end
                        st_q <= bad_mode ? ST_IDLE : ST_XF_RD;
                    end
                end
                ST_XF_RD: begin
                    if (mem_ack_i) begin
                        byte_q <= mem_rdata_i[7:0];
                        st_q <= ST_XF_WR;
                    end
                end
                ST_XF_WR: begin
                    if (mem_ack_i) begin
                        if (rem_q == 10'h000) begin
                            ctl_q[MODE_HI:0] <= MODE_STOP;
                            fin_q <= 1'b1;
                            st_q <= ST_WB_CTL;
                        end else if (grp_q == 10'h000) begin
                            ctl_q[COUNT_HI:COUNT_LO] <= rem_q - 10'h001;
                            rem_q <= rem_q - 10'h001;
                            fin_q <= 1'b0;
                            st_q <= ST_WB_CTL;
                        end else begin
                            rem_q <= rem_q - 10'h001;
                            grp_q <= grp_q - 10'h001;
                            st_q <= ST_XF_RD;
                        end
                    end
                end
                ST_WB_CTL: begin
                    if (mem_ack_i) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // one completion pulse per finished structure
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_q <= '0;
        end else begin
            done_q <= eng_done ? chbit : '0;
        end
    end
    assign dma_done_o = done_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_claim;
        st_q == ST_IDLE ##1 st_q == ST_RD_SRC;
    endsequence

    sequence s_group_end;
        st_q == ST_XF_WR && mem_ack_i && rem_q != 10'h000 && grp_q == 10'h000;
    endsequence

    a_bus_answer_time: assert property (acc && !resp_q |=> !avs_waitrequest_o)
        else $error("bus answer not after one wait cycle");
    a_done_pulse_chan: assert property (eng_done |=> dma_done_o == $past(chbit) ##1 dma_done_o == '0)
        else $error("completion pulse wrong");
    a_basic_disable: assert property (eng_done && cur_mode_q == MODE_BASIC && ena_set == '0 |=> (ena_q & $past(chbit)) == '0)
        else $error("basic channel not disabled");
    a_ping_swap: assert property (eng_done && cur_mode_q == MODE_PING_PONG && alt_set == '0 && alt_clr == '0 |=> (alt_q & $past(chbit)) != ($past(alt_q) & $past(chbit)))
        else $error("ping-pong structure not swapped");
    a_wb_stopped: assert property (st_q == ST_WB_CTL && fin_q |-> mem_o.wdata[MODE_HI:0] == MODE_STOP)
        else $error("completed structure not stopped");
    a_fixed_dest: assert property (st_q == ST_XF_WR && dst_step == STEP_FIXED |-> mem_o.addr == dst_end_q)
        else $error("fixed destination moved");
    a_struct_addr: assert property (st_q == ST_RD_CTL |-> mem_o.addr == ctl_base_q + (32'(ch_q) << 4) + (alt_use_q ? 32'h0000_0200 : 32'h0000_0000) + 32'h0000_0008)
        else $error("control word address wrong");
    a_single_one: assert property (ctl_ack && !burst_q && !bad_mode |=> grp_q == '0 && st_q == ST_XF_RD)
        else $error("single request moved more than one item");
    a_burst_only: assert property (s_claim |-> burst_q || !burst_only_q[ch_q])
        else $error("single request served on burst-only channel");
    a_group_wb: assert property (s_group_end |=> st_q == ST_WB_CTL ##[1:1000] st_q == ST_IDLE)
        else $error("group end did not rearbitrate");
endmodule

/* File: tb/dcp_mem_model.sv */
// Memory and peripheral data register model on the engine's master port
`timescale 1ns/1ps
module dcp_mem_model
    import dcp_pkg::*;
#(
    parameter logic [31:0] PER = 32'h4000_0000
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input dcp_mem_req_t mem_i,
    output logic [31:0] rdata_o,
    output logic ack_o
);
    logic [7:0] m [logic [31:0]];
    logic [7:0] tx_q [$];
    logic [7:0] rx_q;
    int cnt;
    int n_ctl;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_o <= 1'b0;
            rdata_o <= 32'h0000_0000;
            rx_q <= 8'h00;
            cnt <= 0;
        end else begin
            ack_o <= 1'b0;
            // Data lines toggle except when a read is answered
            rdata_o <= ~rdata_o;
            if (mem_i.req && !ack_o) begin
                cnt <= cnt + 1;
                if (cnt >= (slow_i ? 4 : 0)) begin
                    cnt <= 0;
                    ack_o <= 1'b1;
                    if (mem_i.we && mem_i.addr == PER) begin
                        tx_q.push_back(mem_i.wdata[7:0]);
                    end else if (mem_i.we && mem_i.item) begin
                        m[mem_i.addr] = mem_i.wdata[7:0];
                    end else if (mem_i.we) begin
                        n_ctl++;
                        for (int i = 0; i < 4; i++) m[mem_i.addr + i] = mem_i.wdata[8*i +: 8];
                    end else if (mem_i.addr == PER) begin
                        rdata_o <= {24'h00_0000, rx_q};
                        rx_q <= rx_q + 8'h01;
                    end else if (mem_i.item) begin
                        rdata_o <= {24'h00_0000, m[mem_i.addr]};
                    end else begin
                        rdata_o <= {m[mem_i.addr + 3], m[mem_i.addr + 2],
                                    m[mem_i.addr + 1], m[mem_i.addr]};
                    end
                end
            end
        end
    end
endmodule

/* File: tb/test_dma_channel_basic_pingpong.sv */
// Self-checking bench of the peripheral DMA channel engine
`timescale 1ns/1ps
module test_dma_channel_basic_pingpong
    import dcp_pkg::*;
;
    localparam logic [31:0] BASE = 32'h0000_1000;
    localparam logic [31:0] PER = 32'h4000_0000;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [11:0] adr = 12'h000;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic slow = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] single = 32'h0000_0000;
    logic [31:0] burst = 32'h0000_0000;
    logic [31:0] rdat, mrd, done, q;
    logic wreq, mack;
    dcp_mem_req_t mem;
    int n_mismatch = 0;
    int n_tests = 0;
    int done_cnt [32];

    dcp_dma_channel uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .mem_o(mem), .mem_rdata_i(mrd), .mem_ack_i(mack),
        .dma_single_i(single), .dma_burst_i(burst), .dma_done_o(done));
    dcp_mem_model u_mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .mem_i(mem),
        .rdata_o(mrd), .ack_o(mack));

    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) for (int i = 0; i < 32; i++) if (done[i] === 1'b1) done_cnt[i]++;

    task automatic print_verdict();
        $display("mismatches=%0d tests=%0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic hang();
        n_mismatch++;
        print_verdict();
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        for (k = 0; k < 50; k++) begin
            @(posedge clk_i);
            if (wreq === 1'b0) break;
        end
        if (k == 50) hang();
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic wait_done(input int ch, input int n);
        for (int k = 0; k < 20000 && done_cnt[ch] < n; k++) @(posedge clk_i);
        if (done_cnt[ch] < n) hang();
    endtask
    task automatic wait_tx(input int n);
        for (int k = 0; k < 2000 && u_mem.tx_q.size() < n; k++) @(posedge clk_i);
        if (u_mem.tx_q.size() < n) hang();
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] ds, ss, input logic [3:0] ab,
                                        input logic [9:0] n, input logic [2:0] md);
        return {ds, WIDTH_BYTE, ss, WIDTH_BYTE, 6'h00, ab, n, 1'b0, md};
    endfunction
    function automatic logic [31:0] get_w(input logic [31:0] a);
        return {u_mem.m[a + 3], u_mem.m[a + 2], u_mem.m[a + 1], u_mem.m[a]};
    endfunction
    task automatic set_w(input logic [31:0] a, input logic [31:0] d);
        for (int i = 0; i < 4; i++) u_mem.m[a + i] = d[8*i +: 8];
    endtask
    task automatic set_st(input logic [31:0] st, s, d, c);
        set_w(st, s);
        set_w(st + 4, d);
        set_w(st + 8, c);
    endtask

    task automatic t_regs();
        bus(1'b0, OFS_CHANNEL_ENABLE_SET, 32'h0000_0000);
        chk(q, 32'h0000_0000); // idle enable
        bus(1'b0, 12'h040, 32'h0000_0000);
        chk(q, 32'h0000_0000); // unmapped reads zero
        bus(1'b1, OFS_CHANNEL_PRIORITY_SET, 32'h0000_0080);
        bus(1'b0, OFS_CHANNEL_PRIORITY_SET, 32'h0000_0000);
        chk(q, 32'h0000_0080); // high priority
        bus(1'b1, OFS_CHANNEL_PRIORITY_CLEAR, 32'h0000_0080);
        bus(1'b0, OFS_CHANNEL_PRIORITY_SET, 32'h0000_0000);
        chk(q, 32'h0000_0000); // default priority
        bus(1'b1, OFS_CHANNEL_ENABLE_SET, 32'h0000_0001);
        bus(1'b0, OFS_CHANNEL_ENABLE_SET, 32'h0000_0000);
        chk(q, 32'h0000_0001); // enable reads active
        bus(1'b1, OFS_CHANNEL_ENABLE_CLEAR, 32'h0000_0001);
        bus(1'b0, OFS_CHANNEL_ENABLE_SET, 32'h0000_0000);
        chk(q, 32'h0000_0000); // enable cleared
        bus(1'b1, OFS_CONFIG, 32'h0000_0001);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk(q, 32'h0000_0001); // master enabled, idle
        bus(1'b1, OFS_CTL_BASE, BASE);
        bus(1'b0, OFS_ALT_BASE, 32'h0000_0000);
        chk(q, BASE + ALT_STRUCT_OFS); // alternate base
        bus(1'b1, OFS_BURST_ONLY_SET, 32'h0000_0080);
        bus(1'b0, OFS_BURST_ONLY_SET, 32'h0000_0000);
        chk(q, 32'h0000_0080); // bit per channel
        bus(1'b1, OFS_BURST_ONLY_CLEAR, 32'h0000_0080);
        bus(1'b0, OFS_BURST_ONLY_SET, 32'h0000_0000);
        chk(q, 32'h0000_0000); // burst only off
        bus(1'b1, OFS_PRIMARY_SELECT_SET, 32'h0000_0180);
        bus(1'b1, OFS_PRIMARY_SELECT_CLEAR, 32'h0000_0180);
        bus(1'b0, OFS_PRIMARY_SELECT_SET, 32'h0000_0000);
        chk(q, 32'h0000_0000); // primary chosen
    endtask
    task automatic t_basic();
        int c0;
        c0 = u_mem.n_ctl;
        for (int i = 0; i < 64; i++) u_mem.m[32'h0000_2000 + i] = 8'hA5 ^ 8'(i);
        set_st(BASE + 32'h0000_0070, 32'h0000_203F, PER,
               ctl(STEP_FIXED, STEP_BYTE, 4'h2, 10'h03F, MODE_BASIC));
        bus(1'b1, OFS_REQUEST_MASK, 32'h0000_0080);
        bus(1'b1, OFS_CHANNEL_ENABLE_SET, 32'h0000_0080);
        burst[7] <= 1'b1;
        repeat (30) @(posedge clk_i);
        chk(u_mem.tx_q.size(), 0); // masked channel idle
        bus(1'b1, OFS_REQUEST_UNMASK, 32'h0000_0080);
        wait_done(7, 1);
        burst[7] <= 1'b0;
        chk(u_mem.tx_q.size(), 64); // whole count
        for (int i = 0; i < 64; i++) chk(u_mem.tx_q[i], 8'hA5 ^ 8'(i));
        chk(u_mem.n_ctl - c0, 16); // groups of four
        chk(get_w(BASE + 32'h0000_0078) & 32'h0000_0007, 32'h0000_0000); // mode stopped
        bus(1'b0, OFS_CHANNEL_ENABLE_SET, 32'h0000_0000);
        chk(q, 32'h0000_0000); // cleared at end
        repeat (20) @(posedge clk_i);
        chk(done_cnt[7], 1); // one completion
    endtask
    task automatic t_single();
        u_mem.tx_q.delete();
        slow <= 1'b1;
        set_st(BASE + 32'h0000_0070, 32'h0000_2003, PER,
               ctl(STEP_FIXED, STEP_BYTE, 4'h2, 10'h003, MODE_BASIC));
        bus(1'b1, OFS_CHANNEL_ENABLE_SET, 32'h0000_0080);
        single[7] <= 1'b1;
        wait_tx(1);
        single[7] <= 1'b0;
        repeat (40) @(posedge clk_i);
        chk(u_mem.tx_q.size(), 1); // single moves one
        q = get_w(BASE + 32'h0000_0078);
        chk(q[13:4], 10'h002); // count minus one
        bus(1'b1, OFS_BURST_ONLY_SET, 32'h0000_0080);
        single[7] <= 1'b1;
        repeat (40) @(posedge clk_i);
        chk(u_mem.tx_q.size(), 1); // single ignored
        burst[7] <= 1'b1;
        wait_done(7, 2);
        burst[7] <= 1'b0;
        single[7] <= 1'b0;
        for (int i = 0; i < 4; i++) chk(u_mem.tx_q[i], 8'hA5 ^ 8'(i)); // burst rest
    endtask
    task automatic t_ping();
        logic [31:0] c;
        c = ctl(STEP_BYTE, STEP_FIXED, 4'h3, 10'h03F, MODE_PING_PONG);
        slow <= 1'b0;
        set_st(BASE + 32'h0000_0080, PER, 32'h0000_303F, c);
        set_st(BASE + 32'h0000_0280, PER, 32'h0000_313F, c);
        bus(1'b1, OFS_CHANNEL_PRIORITY_SET, 32'h0000_0100);
        bus(1'b1, OFS_CHANNEL_ENABLE_SET, 32'h0000_0100);
        burst[8] <= 1'b1;
        wait_done(8, 1);
        chk(get_w(BASE + 32'h0000_0088) & 32'h0000_0007, 32'h0000_0000); // old stopped
        bus(1'b0, OFS_CHANNEL_ENABLE_SET, 32'h0000_0000);
        chk(q, 32'h0000_0100); // still enabled
        bus(1'b0, OFS_PRIMARY_SELECT_SET, 32'h0000_0000);
        chk(q, 32'h0000_0100); // alternate next
        set_w(BASE + 32'h0000_0088, c);
        wait_done(8, 2);
        chk(get_w(BASE + 32'h0000_0288) & 32'h0000_0007, 32'h0000_0000); // alt stopped
        for (int i = 0; i < 64; i++) begin
            chk(u_mem.m[32'h0000_3000 + i], 8'(i)); // buffer A
            chk(u_mem.m[32'h0000_3100 + i], 8'(64 + i)); // buffer B
        end
        wait_done(8, 3);
        burst[8] <= 1'b0;
        chk(u_mem.m[32'h0000_3000], 8'h80); // back to primary
    endtask

    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_basic();
        t_single();
        t_ping();
        print_verdict();
    end
endmodule
